/* File: design/capacity_flag_load_select.sv */
// Capacity warning flags, condition flags and load-select settings
// of a single-cell gauge, reached over AHB-Lite.
// Assumes one 32-bit AHB-Lite master; single word transfers only.
//
// Overview of operation
// - Initial warning flag sets when capacity drops below first set level.
// - Initial warning flag clears when capacity climbs above its clear level.
// - Final warning flag sets when capacity drops below second set level.
// - A final set level of minus one disables the final warning.
// - Final flag clears only if set and capacity above its clear level.
// - Internal short flag sets on a relaxed-voltage short indication.
// - Tab disconnect flag sets on a health-state disconnect indication.
// - Load mode 0 selects constant current, default; 1 constant power.
// - Control state word mirrors the load mode bit.
// - Current mode codes 0..6, default 1.
// - Power mode codes 0..6, default 0; the code keeps one shared code field, reset to 1 in both modes.
// - Energy scale accepts only 1 or 10.
// - Scale 10 means cWh and cW, temperature rise times ten.
// - Reserve capacity held; reserve rate select bit is stored and read back only.
// - Separate energy reserve is held.
// - Charge accumulator follows sensed charge in both directions.
`timescale 1ns/1ns
module capacity_flag_load_select
    import gauge_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Interrupt
    output logic             irq
);
    import gauge_pkg::*;

    // Bus phase capture
    logic        wr_pend_q;
    logic        rd_pend_q;
    logic [7:0]  addr_q;
    logic        addr_take;

    // Software registers
    logic [15:0] remcap_q;
    logic        remcap_new_q;
    logic [15:0] cap1_set_q;
    logic [15:0] cap1_clr_q;
    logic [15:0] capf_set_q;
    logic [15:0] capf_clr_q;
    logic        mode_q;
    logic [2:0]  sel_q;
    logic [3:0]  scale_q;
    logic        reserve_rate_select_q;
    logic [15:0] rsv_cap_q;
    logic [15:0] rsv_nrg_q;
    logic [15:0] rate_in_q;
    logic [31:0] charge_q;
    logic [num_events-1:0] stat_q;
    logic [num_events-1:0] mask_q;
    logic        short_q;
    logic        tab_q;
    logic [31:0] load_val_q;

    // Block outputs
    logic        init_flag;
    logic        final_flag;
    basis_t      basis;
    logic        power;
    logic        init_prev_q;
    logic        final_prev_q;

    // Address phase is taken only for an active, selected transfer
    assign addr_take = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end else begin
            wr_pend_q <= addr_take && hwrite;
            rd_pend_q <= addr_take && !hwrite;
            if (addr_take) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // Write strobes per register
    logic w_remcap, w_c1s, w_c1c, w_cfs, w_cfc, w_cfg, w_stat, w_mask;
    logic w_rcap, w_rnrg, w_charge, w_cond, w_rate;
    assign w_remcap = wr_pend_q && addr_q == off_remcap;
    assign w_c1s    = wr_pend_q && addr_q == off_cap1_set;
    assign w_c1c    = wr_pend_q && addr_q == off_cap1_clr;
    assign w_cfs    = wr_pend_q && addr_q == off_capf_set;
    assign w_cfc    = wr_pend_q && addr_q == off_capf_clr;
    assign w_cfg    = wr_pend_q && addr_q == off_config;
    assign w_stat   = wr_pend_q && addr_q == off_int_stat;
    assign w_mask   = wr_pend_q && addr_q == off_int_mask;
    assign w_rcap   = wr_pend_q && addr_q == off_rsv_cap;
    assign w_rnrg   = wr_pend_q && addr_q == off_rsv_nrg;
    assign w_charge = wr_pend_q && addr_q == off_charge;
    assign w_cond   = wr_pend_q && addr_q == off_cond;
    assign w_rate   = wr_pend_q && addr_q == off_rate_in;

    // Scale field keeps its old value unless 1 or 10 is written
    logic [3:0] scale_wr;
    logic       scale_ok;
    assign scale_wr = hwdata[cfg_scale_lsb +: cfg_scale_w];
    assign scale_ok = (scale_wr == scale_one) || (scale_wr == scale_ten);

    // Thresholds and settings; stored as written, range check on the scale field only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap1_set_q <= cap1_set_rst;
            cap1_clr_q <= cap1_clr_rst;
            capf_set_q <= capf_set_rst;
            capf_clr_q <= capf_clr_rst;
            mode_q     <= 1'b0;
            sel_q      <= sel_cc_rst;
            scale_q    <= scale_one;
            reserve_rate_select_q   <= 1'b0;
            rsv_cap_q  <= 16'h0000;
            rsv_nrg_q  <= 16'h0000;
            rate_in_q  <= 16'h0000;
        end else begin
            if (w_c1s) cap1_set_q <= hwdata[15:0];
            if (w_c1c) cap1_clr_q <= hwdata[15:0];
            if (w_cfs) capf_set_q <= hwdata[15:0];
            if (w_cfc) capf_clr_q <= hwdata[15:0];
            if (w_cfg) begin
                mode_q   <= hwdata[cfg_mode_bit];
                sel_q    <= hwdata[cfg_sel_lsb +: cfg_sel_w];
                reserve_rate_select_q <= hwdata[cfg_reserve_rate_select_bit];
                if (scale_ok) scale_q <= scale_wr;
            end
            if (w_rcap) rsv_cap_q <= hwdata[15:0];
            if (w_rnrg) rsv_nrg_q <= hwdata[15:0];
            if (w_rate) rate_in_q <= hwdata[15:0];
        end
    end

    // New capacity value triggers a flag update next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remcap_q     <= 16'h0000;
            remcap_new_q <= 1'b0;
        end else begin
            remcap_new_q <= w_remcap;
            if (w_remcap) remcap_q <= hwdata[15:0];
        end
    end

    // Charge accumulator: signed delta adds in either direction
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            charge_q <= 32'h0000_0000;
        end else if (w_charge) begin
            charge_q <= charge_q + hwdata;
        end
    end

    // Condition flags: sticky until written zero via the cond register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            short_q <= 1'b0;
            tab_q   <= 1'b0;
        end else if (w_cond) begin
            short_q <= hwdata[flag_short_bit] | short_q & hwdata[flag_short_bit];
            tab_q   <= hwdata[flag_tab_bit];
        end
    end

    cap_flags u_cap_flags (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .update       (remcap_new_q),
        .remcap       (remcap_q),
        .cap1_set     (cap1_set_q),
        .cap1_clr     (cap1_clr_q),
        .capf_set     (capf_set_q),
        .capf_clr     (capf_clr_q),
        .init_flag_q  (init_flag),
        .final_flag_q (final_flag)
    );

    load_basis u_load_basis (
        .hclk    (hclk),
        .hresetn (hresetn),
        .mode    (mode_q),
        .sel     (sel_q),
        .basis_q (basis),
        .power_q (power)
    );

    // Load value by basis; power units scaled by ten at scale 10
    logic [31:0] load_d;
    logic [31:0] load_raw;
    assign load_raw = (basis == basis_at_rate)   ? {16'h0000, rate_in_q} :
                      (basis == basis_user_rate) ? {16'h0000, rate_in_q} :
                      (basis == basis_none)      ? 32'h0000_0000 :
                      {29'h0, basis};
    assign load_d = (power && scale_q == scale_ten) ?
                    32'(load_raw * 32'd10) : load_raw;

    // Events: rising edges of each flag
    logic [num_events-1:0] ev;
    assign ev[flag_init_bit]  = init_flag && !init_prev_q;
    assign ev[flag_final_bit] = final_flag && !final_prev_q;
    assign ev[flag_short_bit] = w_cond && hwdata[flag_short_bit] && !short_q;
    assign ev[flag_tab_bit]   = w_cond && hwdata[flag_tab_bit] && !tab_q;

    // Sticky status; a new event wins over a same-cycle clear
    genvar gi;
    generate
        for (gi = 0; gi < num_events; gi++) begin : g_stat
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    stat_q[gi] <= 1'b0;
                end else if (ev[gi]) begin
                    stat_q[gi] <= 1'b1;
                end else if (w_stat && hwdata[gi]) begin
                    stat_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q       <= '0;
            init_prev_q  <= 1'b0;
            final_prev_q <= 1'b0;
            load_val_q   <= 32'h0000_0000;
            irq          <= 1'b0;
        end else begin
            if (w_mask) mask_q <= hwdata[num_events-1:0];
            init_prev_q  <= init_flag;
            final_prev_q <= final_flag;
            load_val_q   <= load_d;
            irq          <= |(stat_q & mask_q);
        end
    end

    // Read mux
    logic [31:0] flags_w;
    logic [31:0] ctl_w;
    logic [31:0] cfg_w;
    logic [31:0] rd_d;
    assign flags_w = {28'h0, tab_q, short_q, final_flag, init_flag};
    assign ctl_w   = {28'h0, basis, power};
    assign cfg_w   = {19'h0, reserve_rate_select_q, scale_q, 1'b0, sel_q, 3'h0, mode_q};
    assign rd_d = (addr_q == off_remcap)    ? {16'h0, remcap_q}   :
                  (addr_q == off_cap1_set)  ? {16'h0, cap1_set_q} :
                  (addr_q == off_cap1_clr)  ? {16'h0, cap1_clr_q} :
                  (addr_q == off_capf_set)  ? {16'h0, capf_set_q} :
                  (addr_q == off_capf_clr)  ? {16'h0, capf_clr_q} :
                  (addr_q == off_config)    ? cfg_w                :
                  (addr_q == off_flags)     ? flags_w              :
                  (addr_q == off_ctl_state) ? ctl_w                :
                  (addr_q == off_int_stat)  ? {28'h0, stat_q}      :
                  (addr_q == off_int_mask)  ? {28'h0, mask_q}      :
                  (addr_q == off_rsv_cap)   ? {16'h0, rsv_cap_q}  :
                  (addr_q == off_rsv_nrg)   ? {16'h0, rsv_nrg_q}  :
                  (addr_q == off_load_val)  ? load_val_q           :
                  (addr_q == off_charge)    ? charge_q             :
                  (addr_q == off_rate_in)   ? {16'h0, rate_in_q}  :
                  32'h0000_0000;

    // Writes answer at once; reads take one wait state so that the mux
    // sees settings and condition flags updated by a write that has just landed; capacity flags follow a cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= !(addr_take && !hwrite);
            hresp     <= 1'b0;
            if (rd_pend_q) hrdata <= rd_d;
        end
    end

endmodule // capacity_flag_load_select

/* File: design/gauge_pkg.sv */
// Package: register map, field positions, reset values and codes
// for the capacity-flag and load-select block.
// Assumes a 32-bit AHB-Lite bus with word-aligned registers.
package gauge_pkg;

    // Register byte offsets
    localparam logic [7:0] off_remcap    = 8'h00;
    localparam logic [7:0] off_cap1_set  = 8'h04;
    localparam logic [7:0] off_cap1_clr  = 8'h08;
    localparam logic [7:0] off_capf_set  = 8'h0c;
    localparam logic [7:0] off_capf_clr  = 8'h10;
    localparam logic [7:0] off_config    = 8'h14;
    localparam logic [7:0] off_flags     = 8'h18;
    localparam logic [7:0] off_ctl_state = 8'h1c;
    localparam logic [7:0] off_int_stat  = 8'h20;
    localparam logic [7:0] off_int_mask  = 8'h24;
    localparam logic [7:0] off_rsv_cap   = 8'h28;
    localparam logic [7:0] off_rsv_nrg   = 8'h2c;
    localparam logic [7:0] off_load_val  = 8'h30;
    localparam logic [7:0] off_charge    = 8'h34;
    localparam logic [7:0] off_cond      = 8'h38;
    localparam logic [7:0] off_rate_in   = 8'h3c;

    // Config register fields
    localparam int cfg_mode_bit    = 0;
    localparam int cfg_sel_lsb     = 4;
    localparam int cfg_sel_w       = 3;
    localparam int cfg_scale_lsb   = 8;
    localparam int cfg_scale_w     = 4;
    localparam int cfg_reserve_rate_select_bit  = 12;

    // Flag / interrupt bit positions
    localparam int flag_init_bit   = 0;
    localparam int flag_final_bit  = 1;
    localparam int flag_short_bit  = 2;
    localparam int flag_tab_bit    = 3;
    localparam int num_events      = 4;

    // Reset values
    localparam logic [15:0] cap1_set_rst = 16'h0096;
    localparam logic [15:0] cap1_clr_rst = 16'h00af;
    localparam logic [15:0] capf_set_rst = 16'h004b;
    localparam logic [15:0] capf_clr_rst = 16'h0064;
    localparam logic [15:0] thr_disabled = 16'hffff;   // -1 switches final set off
    localparam logic [3:0]  scale_one    = 4'h1;
    localparam logic [3:0]  scale_ten    = 4'ha;
    localparam logic [2:0]  sel_cc_rst   = 3'h1;
    localparam logic [2:0]  sel_cp_rst   = 3'h0;

    // Load basis codes
    typedef enum logic [2:0] {
        basis_prev_avg, basis_pres_avg, basis_avg_i, basis_filt_i,
        basis_design5, basis_at_rate, basis_user_rate, basis_none
    } basis_t;

endpackage

/* File: design/cap_flags.sv */
// Hysteresis capacity warning flags, updated on each new capacity value.
// Assumes thresholds are stable while update is pulsed.
`timescale 1ns/1ns
module cap_flags
    import gauge_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Capacity sample
    input  wire logic        update,
    input  wire logic [15:0] remcap,
    // Thresholds
    input  wire logic [15:0] cap1_set,
    input  wire logic [15:0] cap1_clr,
    input  wire logic [15:0] capf_set,
    input  wire logic [15:0] capf_clr,
    // Flags
    output logic             init_flag_q,
    output logic             final_flag_q
);
    import gauge_pkg::*;

    logic init_d;
    logic final_d;
    logic final_armed;

    // Final set is disabled when its threshold is -1
    assign final_armed = (capf_set != thr_disabled);
    assign init_d  = (remcap < cap1_set) ? 1'b1 :
                     (remcap > cap1_clr) ? 1'b0 : init_flag_q;
    assign final_d = (final_armed && remcap < capf_set) ? 1'b1 :
                     (final_flag_q && remcap > capf_clr) ? 1'b0 :
                     final_flag_q;

    // Both flags move together on each new sample
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_flag_q  <= 1'b0;
            final_flag_q <= 1'b0;
        end else if (update) begin
            init_flag_q  <= init_d;
            final_flag_q <= final_d;
        end
    end

endmodule // cap_flags

/* File: design/load_basis.sv */
// Decodes load mode and selection code into the load basis in use.
// Assumes code is one of 0..6; seven and up give basis_none.
`timescale 1ns/1ns
module load_basis
    import gauge_pkg::*;
(
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Settings
    input  wire logic       mode,
    input  wire logic [2:0] sel,
    // Decoded basis, registered
    output basis_t          basis_q,
    output logic            power_q
);
    import gauge_pkg::*;

    basis_t basis_d;

    // Same code table in both modes; mode picks current or power units
    assign basis_d = (sel > 3'h6) ? basis_none : basis_t'(sel);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            basis_q <= basis_pres_avg;
            power_q <= 1'b0;
        end else begin
            basis_q <= basis_d;
            power_q <= mode;
        end
    end

endmodule // load_basis

/* File: verification/capacity_flag_load_select_monitor.sv */
// Checker: bus response, config readback, status decode, interrupt gating.
// Assumes one master, single word transfers, hready tied to hreadyout.
`timescale 1ns/1ns
module capacity_flag_load_select_monitor
    import gauge_pkg::*;
(
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Interrupt
    input wire logic        irq
);
    logic       rd_q, wr_q, mv_q;
    logic [7:0] a_q, cfg_q, cfg_d;
    logic [3:0] msk_q, sc;
    wire        rd_cfg = rd_q && hready && a_q == off_config;
    wire        rd_ctl = rd_q && hready && a_q == off_ctl_state;
    wire        mzero  = mv_q && msk_q == 4'h0;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Shadow of mode, code and scale; a bad scale keeps the old one
    assign sc    = hwdata[11:8];
    assign cfg_d = {(sc == scale_one || sc == scale_ten) ? sc : cfg_q[7:4],
                    hwdata[6:4], hwdata[0]};
    // Phase tracking; mask shadow valid only once written
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q  <= 1'b0;
            wr_q  <= 1'b0;
            mv_q  <= 1'b0;
            a_q   <= 8'h00;
            msk_q <= 4'h0;
            cfg_q <= {scale_one, sel_cc_rst, 1'b0};
        end else if (hready) begin
            rd_q <= hsel && htrans[1] && !hwrite;
            wr_q <= hsel && htrans[1] && hwrite;
            a_q  <= haddr[7:0];
            if (wr_q && a_q == off_config) cfg_q <= cfg_d;
            if (wr_q && a_q == off_int_mask) msk_q <= hwdata[3:0];
            if (wr_q && a_q == off_int_mask) mv_q <= 1'b1;
        end
    end
    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("error response seen");
    AST_NO_WAIT: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
        else $error("wait state inserted on write");
    AST_READ_WAIT: assert property (hsel && hready && htrans[1] && !hwrite |=>
        !hreadyout ##1 hreadyout)
        else $error("read not answered after one wait state");
    AST_CFG_READ: assert property (rd_cfg |->
        {hrdata[11:8], hrdata[6:4], hrdata[0]} == cfg_q)
        else $error("config readback differs from written value");
    AST_MODE_MIRROR: assert property (rd_ctl && $stable(cfg_q) |-> hrdata[0] == cfg_q[0])
        else $error("load mode indicator differs from mode");
    AST_BASIS_DECODE: assert property (rd_ctl && $stable(cfg_q) |->
        hrdata[3:1] == cfg_q[3:1])
        else $error("load basis differs from selection code");
    AST_UNMAPPED: assert property (rd_q && hready && a_q >= 8'h40 |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_IRQ_MASKED: assert property (mzero [*2] |-> !irq)
        else $error("interrupt high with all sources masked");
    AST_IRQ_RESET: assert property ($rose(hresetn) |-> !irq [*2])
        else $error("interrupt high right after reset");
    COV_CTL: cover property (rd_ctl);
    COV_CFG: cover property (wr_q && hready && a_q == off_config);
    COV_IRQ: cover property ($rose(irq));
endmodule // capacity_flag_load_select_monitor

bind capacity_flag_load_select capacity_flag_load_select_monitor u_mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

/* File: verification/gauge_host.sv */
// Host processor model: single word AHB-Lite transfers with idle gaps.
// Assumes hready is the one slave's hreadyout.
`timescale 1ns/1ns
module gauge_host
(
    // Clock
    input wire logic        hclk,
    // Bus
    output logic            hsel,
    output logic [31:0]     haddr,
    output logic [1:0]      htrans,
    output logic            hwrite,
    output logic [2:0]      hsize,
    output logic [31:0]     hwdata,
    input wire logic        hready,
    // Idle cycles before each transfer, for slow pacing
    input wire logic [1:0]  gap
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h5a5a_a5a5;
    end
    // One transfer; hwdata flips when not carrying write data
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        repeat (gap) @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hwdata <= ~hwdata;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : ~hwdata;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
    endtask
endmodule // gauge_host

/* File: verification/capacity_flag_load_select_test.sv */
// Testbench: drives the gauge block through the host model, checks reads.
// Assumes 10 MHz hclk; read expectations queued, checked by a watcher.
`timescale 1ns/1ns
module capacity_flag_load_select_test
    import gauge_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, dp_q;
    logic [31:0] haddr, hwdata, hrdata, rs, t;
    logic [1:0]  htrans, gap;
    logic [2:0]  hsize;
    logic [3:0]  sc, cur;
    logic [63:0] expq[$];
    logic [63:0] e;
    int          err_total, cmp_count;
    logic [15:0] rc[9] = '{16'd200, 16'd150, 16'd149, 16'd175, 16'd176, 16'd74, 16'd100,
                           16'd101, 16'd176};
    logic [1:0]  fx[9] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h3, 2'h3, 2'h1, 2'h0};
    logic [3:0]  sct[4] = '{4'ha, 4'h5, 4'h1, 4'h0};
    capacity_flag_load_select DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
    gauge_host host (
        .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .gap(gap));
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d);
    endtask
    // Note the masked expectation, then issue the read
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        expq.push_back({m, x});
        host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic chk_irq(input logic x);
        repeat (2) @(posedge hclk);
        #1;
        cmp_count++;
        if (irq !== x) begin
            err_total++;
            $display("BAD %0t irq %b expected %b", $time, irq, x);
        end
        @(posedge hclk);
    endtask
    task automatic end_sim();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watcher: takes the oldest note at each completed read data phase
    always @(posedge hclk) begin
        if (dp_q && hreadyout === 1'b1) begin
            e = expq.pop_front();
            cmp_count++;
            if ((hrdata & e[63:32]) !== e[31:0]) begin
                err_total++;
                $display("BAD %0t read %h expected %h", $time, hrdata & e[63:32], e[31:0]);
            end
        end
        if (hreadyout === 1'b1) dp_q <= hsel && htrans[1] && !hwrite;
    end
    initial begin
        repeat (5000) @(posedge hclk);
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        end_sim();
    end
    initial begin
        rs = 32'd56;
        gap = 2'h0;
        dp_q = 1'b0;
        err_total = 0;
        cmp_count = 0;
        hresetn = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(off_cap1_set, 32'hffff, {16'h0, cap1_set_rst});
        rd(off_cap1_clr, 32'hffff, {16'h0, cap1_clr_rst});
        rd(off_capf_set, 32'hffff, {16'h0, capf_set_rst});
        rd(off_capf_clr, 32'hffff, {16'h0, capf_clr_rst});
        rd(off_config, 32'h0f71, 32'h0110);
        rd(off_ctl_state, 32'hf, 32'h2);
        $display("defaults done");
        // Capacity sweep across both set and clear levels, varied pacing
        for (int i = 0; i < 9; i++) begin
            gap = 2'(i % 3);
            wr(off_remcap, {16'h0, rc[i]});
            rd(off_flags, 32'h3, {30'h0, fx[i]});
        end
        gap = 2'h0;
        wr(off_capf_set, {16'h0, thr_disabled});
        wr(off_remcap, 32'h0);
        rd(off_flags, 32'h3, 32'h1);
        wr(off_capf_set, {16'h0, capf_set_rst});
        wr(off_remcap, 32'd500);
        rd(off_flags, 32'h3, 32'h0);
        $display("warning flags done");
        // Condition flags set status; mask gates the line
        wr(off_int_stat, 32'hf);
        wr(off_int_mask, 32'h0);
        for (int b = 2; b < 4; b++) begin
            wr(off_cond, 32'h1 << b);
            rd(off_flags, 32'hc, 32'h1 << b);
            rd(off_int_stat, 32'hc, 32'h1 << b);
            chk_irq(1'b0);
            wr(off_int_mask, 32'h1 << b);
            chk_irq(1'b1);
            wr(off_cond, 32'h0);
            wr(off_int_stat, 32'hf);
            chk_irq(1'b0);
            wr(off_int_mask, 32'h0);
        end
        $display("interrupts done");
        for (int m = 0; m < 2; m++) begin
            for (int s = 0; s < 7; s++) begin
                wr(off_config, 32'(32'h100 | (s << 4) | m));
                rd(off_ctl_state, 32'hf, 32'((s << 1) | m));
            end
        end
        $display("load select done");
        // Scale: only 1 and 10 stick, anything else keeps the old value
        cur = scale_one;
        for (int i = 0; i < 8; i++) begin
            t = rnd();
            sc = (i < 4) ? sct[i] : t[3:0];
            if (sc == scale_one || sc == scale_ten) cur = sc;
            wr(off_config, {19'h0, t[4], sc, 8'h0});
            rd(off_config, 32'h1f00, {19'h0, t[4], cur, 8'h0});
        end
        $display("energy scale done");
        // Power mode, at-rate basis, scale 10: load value is rate times ten
        wr(off_rate_in, 32'h0123);
        wr(off_config, 32'h0a51);
        repeat (2) @(posedge hclk);
        rd(off_load_val, 32'hffff_ffff, 32'h0b5e);
        $display("load value done");
        t = rnd();
        wr(off_rsv_cap, {16'h0, t[15:0]});
        wr(off_rsv_nrg, {16'h0, t[31:16]});
        rd(off_rsv_cap, 32'hffff, {16'h0, t[15:0]});
        rd(off_rsv_nrg, 32'hffff, {16'h0, t[31:16]});
        wr(off_charge, {24'h0, t[7:0]});
        wr(off_charge, 32'hffff_fff0);
        rd(off_charge, 32'hffff, {16'h0, {8'h0, t[7:0]} - 16'h10});
        $display("reserves and charge done");
        wr(8'h44, 32'hffff_ffff);
        rd(8'h44, 32'hffff_ffff, 32'h0);
        rd(off_cap1_set, 32'hffff, {16'h0, cap1_set_rst});
        repeat (3) @(posedge hclk);
        $display("unmapped access done");
        end_sim();
    end
endmodule // capacity_flag_load_select_test
